/* File: common/txpa_defs.svh */
// constants of the transmitter mode and amplifier gating control
`ifndef TXPA_DEFS_SVH
`define TXPA_DEFS_SVH
// clock rate and start-up interval
`define TXPA_CLK_HZ        40000000
`define TXPA_TON_US        1000
`define TXPA_TON_CYCLES    ((`TXPA_TON_US * (`TXPA_CLK_HZ / 1000000)))
// divider ratios, half periods in crystal cycles
`define TXPA_DIV_LO_HALF   5'h02
`define TXPA_DIV_HI_HALF   5'h08
`define TXPA_CLKSEL_DIV4   1'h0
// power select thermometer code and step codes
`define TXPA_STEP_W        3
`define TXPA_STEP_OFF      3'h0
`define TXPA_STEP_1        3'h1
`define TXPA_STEP_2        3'h2
`define TXPA_STEP_3        3'h3
`define TXPA_STEP_4        3'h4
`define TXPA_THERM_W       4
// keying pulling switch levels
`define TXPA_PULL_CLOSED   1'h1
// bit positions of the synchronised pin vector
`define TXPA_SYN_EN        0
`define TXPA_SYN_RATIO     1
`define TXPA_SYN_FSK       2
`define TXPA_SYN_LOCK      3
`define TXPA_SYN_LOWV      4
`define TXPA_SYN_THERM     5
`endif

/* File: common/txpa_pkg.sv */
// types of the transmitter mode and amplifier gating control
`default_nettype none
package txpa_pkg;
	typedef enum logic [2:0] {
		TXPA_STANDBY = 3'h1,
		TXPA_STARTUP = 3'h2,
		TXPA_ACTIVE  = 3'h4
	} txpa_mode_t;
endpackage
`default_nettype wire

/* File: common/txpa_div_if.sv */
// carrier between top and clock divider
`default_nettype none
interface txpa_div_if;
	logic enable;
	logic ratio_sel;
	logic clk_level;
	modport ctrl (output enable, output ratio_sel, input clk_level);
	modport div  (input enable, input ratio_sel, output clk_level);
endinterface
`default_nettype wire

/* File: verilog/txpa_clkdiv.sv */
// selectable divide by 4 or 16 clock generator
`include "txpa_defs.svh"
`default_nettype none
module txpa_clkdiv (
	input  wire logic clk_sys_in,
	input  wire logic rst_n,
	txpa_div_if.div   dif
);
	logic [4:0] half_cnt;
	logic       level;
	logic [4:0] half_len;

	// half period chosen by ratio select
	assign half_len = (dif.ratio_sel == `TXPA_CLKSEL_DIV4) ?
		`TXPA_DIV_LO_HALF : `TXPA_DIV_HI_HALF;

	// toggle the level every half period while enabled
	always_ff @(posedge clk_sys_in or negedge rst_n) begin
		if (!rst_n) begin
			half_cnt <= 5'h00;
			level    <= 1'b0;
		end else if (!dif.enable) begin
			half_cnt <= 5'h00;
			level    <= 1'b0;
		end else if (half_cnt >= half_len - 5'h01) begin
			half_cnt <= 5'h00;
			level    <= ~level;
		end else begin
			half_cnt <= half_cnt + 5'h01;
		end
	end
	assign dif.clk_level = level;
endmodule
`default_nettype wire

/* File: verilog/txpa_ctrl.sv */
// transmitter mode control, power step decode and amplifier gating
`include "txpa_defs.svh"
`default_nettype none
module txpa_ctrl #(
	parameter int unsigned TON_CYCLES = `TXPA_TON_CYCLES
) (
	input  wire logic                    clk_sys_in,
	input  wire logic                    nrst_in,
	input  wire logic                    tx_enable_in,
	input  wire logic                    clock_ratio_select_in,
	input  wire logic                    frequency_keying_input_in,
	input  wire logic [`TXPA_THERM_W-1:0] power_therm_in,
	input  wire logic                    pll_lock_in,
	input  wire logic                    low_voltage_in,
	output logic                         divided_clock_output_out,
	output logic                         pa_enable_out,
	output logic [`TXPA_STEP_W-1:0]      pa_step_out,
	output logic [`TXPA_THERM_W-1:0]     pa_source_en_out,
	output logic                         pull_switch_closed_out,
	output logic                         psel_bias_en_out,
	output logic                         active_out
);
	// ======================================================
	// reset release and input synchronisers
	logic [1:0] rst_sync;
	logic       rst_n;
	always_ff @(posedge clk_sys_in or negedge nrst_in) begin
		if (!nrst_in) begin
			rst_sync <= 2'h0;
		end else begin
			rst_sync <= {rst_sync[0], 1'b1};
		end
	end
	assign rst_n = rst_sync[1];

	// pins are sampled only once the released reset has settled
	localparam int NSYNC = `TXPA_SYN_THERM + `TXPA_THERM_W;
	logic [NSYNC-1:0] raw_in;
	logic [NSYNC-1:0] sync1;
	logic [NSYNC-1:0] sync2;
	// pull-down: floating enable reaches the pin as zero on the board
	assign raw_in = {
		power_therm_in,
		low_voltage_in,
		pll_lock_in,
		frequency_keying_input_in,
		clock_ratio_select_in,
		tx_enable_in
	};

	// two flip-flops per asynchronous pin
	genvar gi;
	generate
		for (gi = 0; gi < NSYNC; gi++) begin : g_sync
			always_ff @(posedge clk_sys_in or negedge rst_n) begin
				if (!rst_n) begin
					sync1[gi] <= 1'b0;
					sync2[gi] <= 1'b0;
				end else begin
					sync1[gi] <= raw_in[gi];
					sync2[gi] <= sync1[gi];
				end
			end
		end
	endgenerate

	logic                     en_s;
	logic                     ratio_s;
	logic                     fsk_s;
	logic                     lock_s;
	logic                     lowv_s;
	logic [`TXPA_THERM_W-1:0] therm_s;
	assign en_s    = sync2[`TXPA_SYN_EN];
	assign ratio_s = sync2[`TXPA_SYN_RATIO];
	assign fsk_s   = sync2[`TXPA_SYN_FSK];
	assign lock_s  = sync2[`TXPA_SYN_LOCK];
	assign lowv_s  = sync2[`TXPA_SYN_LOWV];
	assign therm_s = sync2[NSYNC-1:`TXPA_SYN_THERM];

	// ======================================================
	// thermometer decode
	function automatic logic [`TXPA_STEP_W-1:0] therm_to_step(
		input logic [`TXPA_THERM_W-1:0] t
	);
		logic [`TXPA_STEP_W-1:0] s;
		s = `TXPA_STEP_OFF;
		if (t[0]) s = `TXPA_STEP_1;
		if (t[0] && t[1]) s = `TXPA_STEP_2;
		if (t[0] && t[1] && t[2]) s = `TXPA_STEP_3;
		if (&t) s = `TXPA_STEP_4;
		return s;
	endfunction

	// awake covers start-up and active; shared by status, bias and divider
	function automatic logic mode_awake(
		input txpa_pkg::txpa_mode_t m
	);
		return (m != txpa_pkg::TXPA_STANDBY);
	endfunction

	// ======================================================
	// mode state machine
	txpa_pkg::txpa_mode_t mode;
	txpa_pkg::txpa_mode_t next_mode;
	logic [31:0]          ton_cnt;
	logic                 ton_done;
	assign ton_done = (ton_cnt >= TON_CYCLES - 1);

	always_comb begin
		next_mode = mode;
		case (mode)
			txpa_pkg::TXPA_STANDBY: begin
				if (en_s) next_mode = txpa_pkg::TXPA_STARTUP;
			end
			txpa_pkg::TXPA_STARTUP: begin
				if (!en_s) next_mode = txpa_pkg::TXPA_STANDBY;
				else if (ton_done) next_mode = txpa_pkg::TXPA_ACTIVE;
			end
			txpa_pkg::TXPA_ACTIVE: begin
				if (!en_s) next_mode = txpa_pkg::TXPA_STANDBY;
			end
			default: next_mode = txpa_pkg::TXPA_STANDBY;
		endcase
	end

	// mode register
	always_ff @(posedge clk_sys_in or negedge rst_n) begin
		if (!rst_n) mode <= txpa_pkg::TXPA_STANDBY;
		else mode <= next_mode;
	end

	// ======================================================
	// start-up interval counter
	always_ff @(posedge clk_sys_in or negedge rst_n) begin
		if (!rst_n) begin
			ton_cnt <= 32'h0;
		end else if (mode != txpa_pkg::TXPA_STARTUP) begin
			ton_cnt <= 32'h0;
		end else if (!ton_done) begin
			ton_cnt <= ton_cnt + 32'h1;
		end
	end

	// ======================================================
	// amplifier gating and power step
	logic pa_gate;
	// lock, a non-zero power code and supply all gate the amplifier
	assign pa_gate = (mode == txpa_pkg::TXPA_ACTIVE) && lock_s
		&& !lowv_s
		&& (therm_s != {`TXPA_THERM_W{1'b0}});

	always_ff @(posedge clk_sys_in or negedge rst_n) begin
		if (!rst_n) begin
			pa_enable_out    <= 1'b0;
			pa_step_out      <= `TXPA_STEP_OFF;
			pa_source_en_out <= {`TXPA_THERM_W{1'b0}};
		end else begin
			pa_enable_out    <= pa_gate;
			pa_step_out      <= pa_gate ? therm_to_step(therm_s)
				: `TXPA_STEP_OFF;
			pa_source_en_out <= pa_gate ? therm_s
				: {`TXPA_THERM_W{1'b0}};
		end
	end

	// bias source follows the awake state, so it never leads active_out
	// and the select pin floats whenever active_out is low
	always_ff @(posedge clk_sys_in or negedge rst_n) begin
		if (!rst_n) begin
			psel_bias_en_out <= 1'b0;
		end else begin
			psel_bias_en_out <= mode_awake(mode);
		end
	end

	// status and pulling switch
	always_ff @(posedge clk_sys_in or negedge rst_n) begin
		if (!rst_n) begin
			active_out             <= 1'b0;
			pull_switch_closed_out <= `TXPA_PULL_CLOSED;
		end else begin
			active_out             <= mode_awake(mode);
			pull_switch_closed_out <= ~fsk_s;
		end
	end

	// ======================================================
	// divided clock output
	txpa_div_if dif ();
	assign dif.enable    = mode_awake(mode);
	assign dif.ratio_sel = ratio_s;

	txpa_clkdiv u_div (
		.clk_sys_in (clk_sys_in),
		.rst_n      (rst_n),
		.dif        (dif)
	);

	// register the level so the pin comes from a flip-flop
	always_ff @(posedge clk_sys_in or negedge rst_n) begin
		if (!rst_n) divided_clock_output_out <= 1'b0;
		else divided_clock_output_out <= dif.clk_level;
	end
endmodule
`default_nettype wire

/* File: verif/txpa_ctrl_properties.sv */
// concurrent checks on the amplifier gating control ports
`default_nettype none
module txpa_ctrl_properties #(
	parameter int unsigned TON_CYCLES = 8
) (
	input wire logic       clk_sys_in,
	input wire logic       nrst_in,
	input wire logic       tx_enable_in,
	input wire logic       frequency_keying_input_in,
	input wire logic [3:0] power_therm_in,
	input wire logic       pll_lock_in,
	input wire logic       low_voltage_in,
	input wire logic       divided_clock_output_out,
	input wire logic       pa_enable_out,
	input wire logic [3:0] pa_source_en_out,
	input wire logic       pull_switch_closed_out,
	input wire logic       psel_bias_en_out,
	input wire logic       active_out
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge clk_sys_in); endclocking
	default disable iff (!nrst_in);
	// ==========================================================
	// mode, gating and keying relations
	sequence s_on;
		$rose(active_out);
	endsequence
	property p_stby;
		!tx_enable_in[*8] |-> !active_out && !divided_clock_output_out;
	endproperty
	a_stby: assert property (p_stby) else $error("not in standby");
	property p_hiz;
		!active_out |-> !psel_bias_en_out;
	endproperty
	a_hiz: assert property (p_hiz) else $error("select pin loaded");
	property p_wake;
		tx_enable_in[*8] |-> active_out && psel_bias_en_out;
	endproperty
	a_wake: assert property (p_wake) else $error("not awake");
	property p_lock;
		!pll_lock_in[*6] |-> !pa_enable_out;
	endproperty
	a_lock: assert property (p_lock) else $error("amp on unlocked");
	property p_lowv;
		low_voltage_in[*6] |-> !pa_enable_out;
	endproperty
	a_lowv: assert property (p_lowv) else $error("amp on low supply");
	property p_ask;
		(power_therm_in == 4'h0)[*6] |-> !pa_enable_out;
	endproperty
	a_ask: assert property (p_ask) else $error("amp on keyed off");
	property p_start;
		s_on |-> !pa_enable_out[*8];
	endproperty
	a_start: assert property (p_start) else $error("amp on early");
	property p_off;
		!pa_enable_out |-> pa_source_en_out == 4'h0;
	endproperty
	a_off: assert property (p_off) else $error("source on while off");
	property p_fsk;
		frequency_keying_input_in[*8] |-> !pull_switch_closed_out;
	endproperty
	a_fsk: assert property (p_fsk) else $error("pull switch closed");
endmodule
bind txpa_ctrl txpa_ctrl_properties #(.TON_CYCLES(TON_CYCLES)) chk (
	.clk_sys_in                (clk_sys_in),
	.nrst_in                   (nrst_in),
	.tx_enable_in              (tx_enable_in),
	.frequency_keying_input_in (frequency_keying_input_in),
	.power_therm_in            (power_therm_in),
	.pll_lock_in               (pll_lock_in),
	.low_voltage_in            (low_voltage_in),
	.divided_clock_output_out  (divided_clock_output_out),
	.pa_enable_out             (pa_enable_out),
	.pa_source_en_out          (pa_source_en_out),
	.pull_switch_closed_out    (pull_switch_closed_out),
	.psel_bias_en_out          (psel_bias_en_out),
	.active_out                (active_out)
);
`default_nettype wire

/* File: verif/txpa_mcu_model.sv */
// controller side model that measures the divided clock period
`default_nettype none
module txpa_mcu_model (
	input  wire logic       clk_in,
	input  wire logic       ck_in,
	output logic [7:0]      period_out
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] cnt;
	logic       ck_d;
	// count system cycles between rising edges of the received clock
	always_ff @(posedge clk_in) begin
		ck_d <= ck_in;
		cnt <= (ck_in && !ck_d) ? 8'h01 : cnt + 8'h01;
		if (ck_in && !ck_d) period_out <= cnt;
	end
endmodule
`default_nettype wire

/* File: verif/tx_mode_and_pa_gating_ctrl_bench.sv */
// self-checking bench of the amplifier gating control
`default_nettype none
module tx_mode_and_pa_gating_ctrl_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic       clk_sys_in = 1'h0, nrst_in = 1'h0, tx_enable_in = 1'h0;
	logic       clock_ratio_select_in = 1'h0, pll_lock_in = 1'h0;
	logic       frequency_keying_input_in = 1'h0, low_voltage_in = 1'h0;
	logic [3:0] power_therm_in = 4'h0, pa_source_en_out;
	logic [2:0] pa_step_out;
	logic       divided_clock_output_out, pa_enable_out, active_out;
	logic       pull_switch_closed_out, psel_bias_en_out;
	logic [7:0] period;
	int         n_mismatch = 0, tests_run = 0, cycles = 0;
	txpa_ctrl #(.TON_CYCLES(8)) dut (
		.clk_sys_in                (clk_sys_in),
		.nrst_in                   (nrst_in),
		.tx_enable_in              (tx_enable_in),
		.clock_ratio_select_in     (clock_ratio_select_in),
		.frequency_keying_input_in (frequency_keying_input_in),
		.power_therm_in            (power_therm_in),
		.pll_lock_in               (pll_lock_in),
		.low_voltage_in            (low_voltage_in),
		.divided_clock_output_out  (divided_clock_output_out),
		.pa_enable_out             (pa_enable_out),
		.pa_step_out               (pa_step_out),
		.pa_source_en_out          (pa_source_en_out),
		.pull_switch_closed_out    (pull_switch_closed_out),
		.psel_bias_en_out          (psel_bias_en_out),
		.active_out                (active_out)
	);
	txpa_mcu_model mcu (.clk_in(clk_sys_in), .ck_in(divided_clock_output_out),
		.period_out(period));
	// clock and hang guard
	initial forever #12.5 clk_sys_in = ~clk_sys_in;
	always @(posedge clk_sys_in) begin
		cycles++;
		if (cycles == 3000) begin
			n_mismatch++;
			test_done();
		end
	end
	task automatic chk(input logic [7:0] got, exp, input string what);
		tests_run++;
		if (got !== exp) begin
			n_mismatch++;
			$display("wrong value at %0t: %s %h not %h", $time, what, got, exp);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(negedge clk_sys_in);
	endtask
	task automatic t_start();
		int i;
		power_therm_in = 4'hF;
		pll_lock_in = 1'h1;
		tx_enable_in = 1'h1;
		for (i = 0; i < 40 && pa_enable_out !== 1'h1; i++) tick(1);
		chk(8'(i > 10), 8'h01, "start-up length");
		chk({4'h0, pa_enable_out, pa_step_out}, 8'h0C, "top step");
		chk({6'h0, active_out, psel_bias_en_out}, 8'h03, "awake");
		$display("start-up test done");
	endtask
	task automatic t_steps();
		logic [3:0] codes [5] = '{4'h0, 4'h1, 4'h3, 4'h7, 4'hF};
		for (int k = 0; k < 5; k++) begin
			power_therm_in = codes[k];
			tick(6);
			chk({1'h0, pa_step_out, pa_source_en_out}, {1'h0, 3'(k), codes[k]},
				"power step");
		end
		$display("step test done");
	endtask
	task automatic t_gate();
		logic [1:0] cs [3] = '{2'h0, 2'h3, 2'h2};
		for (int k = 0; k < 3; k++) begin
			{pll_lock_in, low_voltage_in} = cs[k];
			tick(6);
			chk(8'(pa_enable_out), 8'(k == 2), "amp gating");
		end
		$display("gating test done");
	endtask
	task automatic t_keys();
		for (int b = 0; b < 2; b++) begin
			frequency_keying_input_in = 1'(b);
			clock_ratio_select_in = 1'(b);
			tick(40);
			chk(8'(pull_switch_closed_out), 8'(b == 0), "pull switch");
			chk(period, (b == 1) ? 8'h10 : 8'h04, "clock period");
		end
		$display("keying and clock test done");
	endtask
	task automatic t_stby();
		tx_enable_in = 1'h0;
		tick(8);
		chk({4'h0, active_out, psel_bias_en_out, pa_enable_out,
			divided_clock_output_out}, 8'h00, "standby");
		$display("standby test done");
	endtask
	task automatic t_reset();
		int i;
		tx_enable_in = 1'h1;
		frequency_keying_input_in = 1'h1;
		tick(20);
		nrst_in = 1'h0;
		tick(1);
		chk({3'h0, active_out, psel_bias_en_out, pa_enable_out,
			pull_switch_closed_out, divided_clock_output_out}, 8'h02,
			"reset values");
		nrst_in = 1'h1;
		for (i = 0; i < 40 && pa_enable_out !== 1'h1; i++) tick(1);
		chk(8'(i > 10), 8'h01, "restart length");
		$display("reset test done");
	endtask
	task automatic test_done();
		$display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	// main sequence
	initial begin
		tick(2);
		nrst_in = 1'h1;
		tick(2);
		t_start();
		t_steps();
		t_gate();
		t_keys();
		t_stby();
		t_reset();
		test_done();
	end
endmodule
`default_nettype wire
